// [shared/ppd_pkg.sv]
// Purpose: Constants for the parallel port data, direction and pull block
// Assumes: AHB-Lite register access, one 32-bit word per register
// Notes: Register byte address is four times the register index
`default_nettype none
package ppd_pkg;
  // ==========================================================
  // Bus widths
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int IDX_W = 14;
  // ==========================================================
  // Register indices
  localparam logic [IDX_W-1:0] IDX_PORT_B_DATA = 14'h0001;
  localparam logic [IDX_W-1:0] IDX_PORT_C_DATA = 14'h0002;
  localparam logic [IDX_W-1:0] IDX_PORT_A_DIRECTION = 14'h0003;
  localparam logic [IDX_W-1:0] IDX_PORT_B_DIRECTION = 14'h0004;
  localparam logic [IDX_W-1:0] IDX_PORT_C_DIRECTION = 14'h0005;
  localparam logic [IDX_W-1:0] IDX_PORT_A_PULL_ENABLE = 14'h18E0;
  // ==========================================================
  // Reset values and field layout
  localparam logic [7:0] PORT_RESET = 8'h00;
  localparam logic [7:0] PORT_C_MASK = 8'h01;
  localparam int OUTPUT_ONLY_BIT = 7;
  localparam logic [7:0] I2C_PIN_MASK = 8'h30;
  // ==========================================================
  // Bus codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'h0;
  localparam logic [1:0] BYTE_LANE_ZERO = 2'h0;
endpackage : ppd_pkg
`default_nettype wire

// [hdl/ppd_gpio.sv]
// Purpose: Port B and C data, port A to C direction, port A pull enable
// Assumes: Pins synchronous to mclk_in, zero wait state AHB-Lite slave
// Notes: Port A output level comes from its owner outside this block
`default_nettype none
module ppd_gpio
  import ppd_pkg::*;
(
  input wire logic mclk_in, // Bus clock
  input wire logic arst_n_in, // Async reset, active low
  input wire logic hsel_in, // Slave select
  input wire logic [ADDR_W-1:0] haddr_in, // Byte address
  input wire logic [1:0] htrans_in, // Transfer type
  input wire logic hwrite_in, // Write when high
  input wire logic [2:0] hsize_in, // Transfer size
  input wire logic [DATA_W-1:0] hwdata_in, // Write data
  input wire logic hready_in, // Bus ready
  output logic [DATA_W-1:0] hrdata_out, // Read data
  output logic hreadyout_out, // Slave ready
  output logic hresp_out, // Response
  input wire logic [7:0] pb_pin_in, // Port B pin levels
  input wire logic pc_pin_in, // Port C pin level
  input wire logic [7:0] pb_analog_in, // Port B analog selected
  input wire logic pc_analog_in, // Port C analog selected
  output logic [7:0] pb_pin_out, // Port B drive level
  output logic [7:0] pb_pin_oe_out, // Port B drive enable
  output logic pc_pin_out, // Port C drive level
  output logic pc_pin_oe_out, // Port C drive enable
  input wire logic [7:0] pa_analog_in, // Port A analog selected
  input wire logic [7:0] pa_out_periph_in, // Output peripheral selected
  input wire logic [7:0] pa_in_periph_in, // Pulse width timer input selected
  input wire logic [7:0] pa_i2c_in, // I2C data or clock selected
  input wire logic [7:0] pa_dbg_rst_in, // Debug or reset function selected
  input wire logic [7:0] pa_out_level_in, // Level driven on port A
  output logic [7:0] pa_pin_oe_out, // Port A GPIO drive enable
  output logic [7:0] pa_pullup_out // Port A pullup on
);

  // ==========================================================
  // Register state
  logic [7:0] port_b_data; // Stored port B data
  logic port_c_data; // Stored port C data bit
  logic [7:0] port_a_direction; // Port A direction
  logic [7:0] port_b_direction; // Port B direction
  logic port_c_direction; // Port C direction bit
  logic [7:0] port_a_pull_enable; // Port A pull enable
  logic [7:0] next_port_b_data; // Value after this edge
  logic next_port_c_data; // Value after this edge
  logic [7:0] next_port_a_direction; // Value after this edge
  logic [7:0] next_port_b_direction; // Value after this edge
  logic next_port_c_direction; // Value after this edge
  logic [7:0] next_port_a_pull_enable; // Value after this edge

  // ==========================================================
  // Bus phase state
  logic wr_pend; // Write in data phase
  logic [IDX_W-1:0] wr_idx; // Index of pending write
  logic addr_take; // Valid address phase now
  logic [IDX_W-1:0] req_idx; // Index of current request
  logic [DATA_W-1:0] next_rdata; // Read data for next phase

  // ==========================================================
  // Synchroniser state
  logic [7:0] pb_meta; // First stage port B
  logic [7:0] pb_sync; // Second stage port B
  logic pc_meta; // First stage port C
  logic pc_sync; // Second stage port C

  // ==========================================================
  // Read value of one port bit group
  function automatic logic [7:0] read_port(input logic [7:0] dir, input logic [7:0] data,
                                           input logic [7:0] pin, input logic [7:0] analog);
    logic [7:0] val;
    val = (dir & data) | (~dir & pin);
    return val & ~analog;
  endfunction : read_port

  // Register index of a word-aligned address
  function automatic logic [IDX_W-1:0] addr_index(input logic [ADDR_W-1:0] addr);
    return addr[ADDR_W-1:2];
  endfunction : addr_index

  // ==========================================================
  // Pin synchronisers
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pb_meta <= PORT_RESET;
      pb_sync <= PORT_RESET;
      pc_meta <= 1'b0;
      pc_sync <= 1'b0;
    end else begin
      pb_meta <= pb_pin_in;
      pb_sync <= pb_meta;
      pc_meta <= pc_pin_in;
      pc_sync <= pc_meta;
    end
  end

  // ==========================================================
  // Address phase decode
  always_comb begin
    // Valid transfer: selected, ready, NONSEQ or SEQ, at any byte offset
    addr_take = hsel_in && hready_in && (htrans_in == HTRANS_NONSEQ || htrans_in == HTRANS_SEQ);
    req_idx = addr_index(haddr_in);
    if (haddr_in[1:0] != BYTE_LANE_ZERO) begin
      // Misaligned maps to nothing
      req_idx = '0;
    end
  end

  // Capture write address for the data phase
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_pend <= 1'b0;
      wr_idx <= '0;
    end else if (hready_in) begin
      wr_pend <= addr_take && hwrite_in;
      wr_idx <= req_idx;
    end
  end

  // ==========================================================
  // Next register values from data phase writes
  always_comb begin
    next_port_b_data = port_b_data;
    next_port_c_data = port_c_data;
    next_port_a_direction = port_a_direction;
    next_port_b_direction = port_b_direction;
    next_port_c_direction = port_c_direction;
    next_port_a_pull_enable = port_a_pull_enable;
    if (wr_pend) begin
      case (wr_idx)
        IDX_PORT_B_DATA: begin
          next_port_b_data = hwdata_in[7:0];
        end
        IDX_PORT_C_DATA: begin
          next_port_c_data = hwdata_in[0];
        end
        IDX_PORT_A_DIRECTION: begin
          next_port_a_direction = hwdata_in[7:0];
        end
        IDX_PORT_B_DIRECTION: begin
          next_port_b_direction = hwdata_in[7:0];
        end
        IDX_PORT_C_DIRECTION: begin
          next_port_c_direction = hwdata_in[0];
        end
        IDX_PORT_A_PULL_ENABLE: begin
          next_port_a_pull_enable = hwdata_in[7:0];
        end
        default: begin
          // Unmapped writes ignored
        end
      endcase
    end
  end

  // Register update
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      port_b_data <= PORT_RESET;
      port_c_data <= 1'b0;
      port_a_direction <= PORT_RESET;
      port_b_direction <= PORT_RESET;
      port_c_direction <= 1'b0;
      port_a_pull_enable <= PORT_RESET;
    end else begin
      port_b_data <= next_port_b_data;
      port_c_data <= next_port_c_data;
      port_a_direction <= next_port_a_direction;
      port_b_direction <= next_port_b_direction;
      port_c_direction <= next_port_c_direction;
      port_a_pull_enable <= next_port_a_pull_enable;
    end
  end

  // ==========================================================
  // Read data, built from post-write values so back-to-back works
  always_comb begin
    logic [7:0] pb_level;
    pb_level = pb_sync;
    pb_level[OUTPUT_ONLY_BIT] = next_port_b_data[OUTPUT_ONLY_BIT];
    next_rdata = '0;
    case (req_idx)
      IDX_PORT_B_DATA: begin
        next_rdata[7:0] = read_port(next_port_b_direction | (8'h01 << OUTPUT_ONLY_BIT),
                                    next_port_b_data, pb_level, pb_analog_in);
      end
      IDX_PORT_C_DATA: begin
        next_rdata[7:0] = read_port({7'h00, next_port_c_direction}, {7'h00, next_port_c_data},
                                    {7'h00, pc_sync}, {7'h00, pc_analog_in}) & PORT_C_MASK;
      end
      IDX_PORT_A_DIRECTION: begin
        next_rdata[7:0] = next_port_a_direction;
      end
      IDX_PORT_B_DIRECTION: begin
        next_rdata[7:0] = next_port_b_direction;
      end
      IDX_PORT_C_DIRECTION: begin
        next_rdata[7:0] = {7'h00, next_port_c_direction};
      end
      IDX_PORT_A_PULL_ENABLE: begin
        next_rdata[7:0] = next_port_a_pull_enable;
      end
      default: begin
        // Unmapped reads zero
        next_rdata = '0;
      end
    endcase
  end

  // Bus answer registers, zero wait state, always OKAY
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hrdata_out <= '0;
      hreadyout_out <= 1'b1;
      hresp_out <= HRESP_OKAY;
    end else begin
      hreadyout_out <= 1'b1;
      hresp_out <= HRESP_OKAY;
      if (addr_take && !hwrite_in) begin
        // Read answered in next data phase
        hrdata_out <= next_rdata;
      end
    end
  end

  // ==========================================================
  // Pin drive for ports B and C
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pb_pin_out <= PORT_RESET;
      pb_pin_oe_out <= PORT_RESET;
      pc_pin_out <= 1'b0;
      pc_pin_oe_out <= 1'b0;
    end else begin
      pb_pin_out <= port_b_data;
      pb_pin_oe_out <= port_b_direction & ~pb_analog_in;
      pc_pin_out <= port_c_data;
      pc_pin_oe_out <= port_c_direction & ~pc_analog_in;
    end
  end

  // ==========================================================
  // Port A drive enable and pullup control
  always_ff @(posedge mclk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pa_pin_oe_out <= PORT_RESET;
      pa_pullup_out <= PORT_RESET;
    end else begin
      pa_pin_oe_out <= port_a_direction & ~pa_analog_in;
      for (int i = 0; i < 8; i++) begin
        if (pa_analog_in[i]) begin
          pa_pullup_out[i] <= 1'b0;
        end else if (pa_dbg_rst_in[i]) begin
          pa_pullup_out[i] <= 1'b1;
        end else if (pa_i2c_in[i] && I2C_PIN_MASK[i]) begin
          // Kept while released or driving high, dropped while driving low
          pa_pullup_out[i] <= port_a_pull_enable[i] &
                              (~port_a_direction[i] | pa_out_level_in[i]);
        end else if (port_a_direction[i] || pa_out_periph_in[i] || pa_in_periph_in[i]) begin
          pa_pullup_out[i] <= 1'b0;
        end else begin
          pa_pullup_out[i] <= port_a_pull_enable[i];
        end
      end
    end
  end

endmodule : ppd_gpio
`default_nettype wire

// [testbench/ppd_gpio_assertions.sv]
// Purpose: Pin, pullup and read data relations of ppd_gpio
// Assumes: One clock domain, outputs registered one cycle after inputs
// Notes: Bound to every ppd_gpio instance at the foot of this file
`default_nettype none
module ppd_gpio_assertions
  import ppd_pkg::*;
(
  input wire logic mclk_in,
  input wire logic arst_n_in,
  input wire logic hsel_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [DATA_W-1:0] hrdata_out,
  input wire logic [7:0] pb_analog_in,
  input wire logic pc_analog_in,
  input wire logic [7:0] pb_pin_oe_out,
  input wire logic pc_pin_oe_out,
  input wire logic [7:0] pa_analog_in,
  input wire logic [7:0] pa_out_periph_in,
  input wire logic [7:0] pa_in_periph_in,
  input wire logic [7:0] pa_i2c_in,
  input wire logic [7:0] pa_dbg_rst_in,
  input wire logic [7:0] pa_out_level_in,
  input wire logic [7:0] pa_pin_oe_out,
  input wire logic [7:0] pa_pullup_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!arst_n_in);
  property p_pb_oe_an; (pb_pin_oe_out & $past(pb_analog_in)) == 8'h00; endproperty
  a_pb_oe_an: assert property (p_pb_oe_an) else $error("port B drives analog pin");
  property p_pc_oe_an; $past(pc_analog_in) |-> !pc_pin_oe_out; endproperty
  a_pc_oe_an: assert property (p_pc_oe_an) else $error("port C drives analog pin");
  property p_pa_oe_an; (pa_pin_oe_out & $past(pa_analog_in)) == 8'h00; endproperty
  a_pa_oe_an: assert property (p_pa_oe_an) else $error("port A drives analog pin");
  property p_pu_an; (pa_pullup_out & $past(pa_analog_in)) == 8'h00; endproperty
  a_pu_an: assert property (p_pu_an) else $error("pullup on analog pin");
  property p_pu_dbg; (~pa_pullup_out & $past(pa_dbg_rst_in & ~pa_analog_in)) == 8'h00; endproperty
  a_pu_dbg: assert property (p_pu_dbg) else $error("debug pin pullup off");
  property p_pu_per;
    (pa_pullup_out & $past((pa_out_periph_in | pa_in_periph_in) & ~pa_dbg_rst_in &
      ~(pa_i2c_in & I2C_PIN_MASK))) == 8'h00;
  endproperty
  a_pu_per: assert property (p_pu_per) else $error("pullup on peripheral pin");
  property p_pu_out;
    (pa_pullup_out & pa_pin_oe_out & ~$past(pa_dbg_rst_in | (pa_i2c_in & I2C_PIN_MASK & pa_out_level_in))) == 8'h00;
  endproperty
  a_pu_out: assert property (p_pu_out) else $error("pullup on output pin");
  property p_rd_hold; !$past(hsel_in && hready_in && htrans_in[1] && !hwrite_in) |-> $stable(hrdata_out); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved without read");
  property p_rd_upper; hrdata_out[31:8] == 24'h000000; endproperty
  a_rd_upper: assert property (p_rd_upper) else $error("read data upper bits set");
endmodule : ppd_gpio_assertions
bind ppd_gpio ppd_gpio_assertions chk_i (.mclk_in, .arst_n_in, .hsel_in, .htrans_in, .hwrite_in, .hready_in,
  .hrdata_out, .pb_analog_in, .pc_analog_in, .pb_pin_oe_out, .pc_pin_oe_out, .pa_analog_in, .pa_out_periph_in,
  .pa_in_periph_in, .pa_i2c_in, .pa_dbg_rst_in, .pa_out_level_in, .pa_pin_oe_out, .pa_pullup_out);
`default_nettype wire

// [testbench/ppd_pins.sv]
// Purpose: Package pins of ports B and C
// Assumes: Undriven pins follow the external level set by the bench
// Notes: No pull devices modelled on ports B and C
`default_nettype none
module ppd_pins (
  input wire logic [7:0] pb_drive_in,
  input wire logic [7:0] pb_oe_in,
  input wire logic pc_drive_in,
  input wire logic pc_oe_in,
  input wire logic [7:0] pb_ext_in,
  input wire logic pc_ext_in,
  output logic [7:0] pb_level_out,
  output logic pc_level_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Pin level: own drive wins, else the outside level
  assign pb_level_out = (pb_oe_in & pb_drive_in) | (~pb_oe_in & pb_ext_in);
  assign pc_level_out = pc_oe_in ? pc_drive_in : pc_ext_in;
endmodule : ppd_pins
`default_nettype wire

// [testbench/ppd_gpio_tb.sv]
// Purpose: Register and pin tests of ppd_gpio over AHB-Lite
// Assumes: Zero wait slave, pins modelled by ppd_pins
// Notes: Pullup priority as chosen by the designer
`default_nettype none
module ppd_gpio_tb
  import ppd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Signals
  logic mclk_in = 1'b0, arst_n_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0, hreadyout_out, hresp_out;
  logic [15:0] haddr_in = 16'h0000;
  logic [1:0] htrans_in = 2'h0;
  logic [31:0] hwdata_in = 32'h00000000, hrdata_out, rd;
  logic [7:0] pb_pin_in, pb_analog_in = 8'h00, pb_pin_out, pb_pin_oe_out, pb_ext = 8'h00;
  logic pc_pin_in, pc_analog_in = 1'b0, pc_pin_out, pc_pin_oe_out, pc_ext = 1'b0;
  logic [7:0] pa_analog_in = 8'h00, pa_out_periph_in = 8'h00, pa_in_periph_in = 8'h00, pa_pin_oe_out;
  logic [7:0] pa_i2c_in = 8'h00, pa_dbg_rst_in = 8'h00, pa_out_level_in = 8'h00, pa_pullup_out;
  logic [IDX_W-1:0] regs [7] = '{14'h0000, IDX_PORT_B_DATA, IDX_PORT_C_DATA, IDX_PORT_A_DIRECTION,
    IDX_PORT_B_DIRECTION, IDX_PORT_C_DIRECTION, IDX_PORT_A_PULL_ENABLE};
  int fail_count = 0, comparisons = 0;
  ppd_gpio uut (.mclk_in, .arst_n_in, .hsel_in, .haddr_in, .htrans_in, .hwrite_in, .hsize_in(3'h2), .hwdata_in,
    .hready_in(hreadyout_out), .hrdata_out, .hreadyout_out, .hresp_out, .pb_pin_in, .pc_pin_in, .pb_analog_in,
    .pc_analog_in, .pb_pin_out, .pb_pin_oe_out, .pc_pin_out, .pc_pin_oe_out, .pa_analog_in, .pa_out_periph_in,
    .pa_in_periph_in, .pa_i2c_in, .pa_dbg_rst_in, .pa_out_level_in, .pa_pin_oe_out, .pa_pullup_out);
  ppd_pins pins (.pb_drive_in(pb_pin_out), .pb_oe_in(pb_pin_oe_out), .pc_drive_in(pc_pin_out),
    .pc_oe_in(pc_pin_oe_out), .pb_ext_in(pb_ext), .pc_ext_in(pc_ext), .pb_level_out(pb_pin_in),
    .pc_level_out(pc_pin_in));
  // 100 MHz clock
  always #5 mclk_in = ~mclk_in;
  // ==========================================================
  // Tasks
  // One AHB-Lite single transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] d);
    hsel_in <= 1'b1;
    haddr_in <= {idx, 2'h0};
    htrans_in <= HTRANS_NONSEQ;
    hwrite_in <= wr;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= {24'h000000, d};
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask : bus
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rdc(input logic [IDX_W-1:0] idx, input logic [7:0] e);
    bus(1'b0, idx, 8'h00);
    chk(rd, {24'h000000, e});
  endtask : rdc
  task automatic end_sim;
    $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  // Watchdog
  initial begin
    #20us;
    fail_count++;
    end_sim();
  end
  // ==========================================================
  // Tests
  initial begin
    repeat (3) @(posedge mclk_in);
    arst_n_in <= 1'b1;
    @(posedge mclk_in);
    chk({pa_pullup_out, pa_pin_oe_out, pb_pin_out, pb_pin_oe_out}, 32'h00000000);
    chk({30'h00000000, hreadyout_out, hresp_out}, {30'h00000000, 1'b1, HRESP_OKAY});
    foreach (regs[i]) rdc(regs[i], 8'h00);
    pb_ext <= 8'hA5;
    repeat (2) @(posedge mclk_in);
    rdc(IDX_PORT_B_DATA, 8'h25);
    bus(1'b1, IDX_PORT_B_DATA, 8'h3C);
    bus(1'b1, IDX_PORT_B_DIRECTION, 8'h0F);
    rdc(IDX_PORT_B_DIRECTION, 8'h0F);
    rdc(IDX_PORT_B_DATA, 8'h2C);
    chk({16'h0000, pb_pin_out, pb_pin_oe_out}, 32'h00003C0F);
    pb_analog_in <= 8'h0C;
    repeat (2) @(posedge mclk_in);
    rdc(IDX_PORT_B_DATA, 8'h20);
    chk({24'h000000, pb_pin_oe_out}, 32'h00000003);
    bus(1'b1, IDX_PORT_C_DATA, 8'hFF);
    rdc(IDX_PORT_C_DATA, 8'h00);
    bus(1'b1, IDX_PORT_C_DIRECTION, 8'hFF);
    rdc(IDX_PORT_C_DIRECTION, 8'h01);
    rdc(IDX_PORT_C_DATA, 8'h01);
    chk({30'h00000000, pc_pin_out, pc_pin_oe_out}, 32'h00000003);
    pc_analog_in <= 1'b1;
    pa_out_periph_in <= 8'h01;
    pa_in_periph_in <= 8'h02;
    pa_analog_in <= 8'h04;
    pa_dbg_rst_in <= 8'h08;
    pa_i2c_in <= 8'h30;
    pa_out_level_in <= 8'h10;
    repeat (2) @(posedge mclk_in);
    rdc(IDX_PORT_C_DATA, 8'h00);
    bus(1'b1, IDX_PORT_A_DIRECTION, 8'hB0);
    bus(1'b1, IDX_PORT_A_PULL_ENABLE, 8'hFF);
    rdc(IDX_PORT_A_PULL_ENABLE, 8'hFF);
    chk({16'h0000, pa_pullup_out, pa_pin_oe_out}, 32'h000058B0);
    bus(1'b1, IDX_PORT_A_PULL_ENABLE, 8'h00);
    rdc(IDX_PORT_A_PULL_ENABLE, 8'h00);
    chk({16'h0000, pa_pullup_out, pa_pin_oe_out}, 32'h000008B0);
    end_sim();
  end
endmodule : ppd_gpio_tb
`default_nettype wire
